// ===== inc/pss_pkg.sv
`default_nettype none
package pss_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] PSS_OFS_PC_LOW = 8'h06;
    localparam logic [7:0] PSS_OFS_TBL_LOW = 8'h07;
    localparam logic [7:0] PSS_OFS_TBL_HIGH_LATCH = 8'h08;
    localparam logic [7:0] PSS_OFS_TBL_HIGH_PTR = 8'h1F;
    localparam logic [7:0] PSS_OFS_CTRL = 8'h30;
    localparam logic [7:0] PSS_OFS_STATUS = 8'h31;
    localparam logic [7:0] PSS_OFS_IRQ = 8'h32;
    // CTRL bits
    localparam int PSS_CTRL_GIE = 0;
    localparam int PSS_CTRL_EN_USB = 1;
    localparam int PSS_CTRL_EN_T0 = 2;
    localparam int PSS_CTRL_EN_T1 = 3;
    localparam int PSS_CTRL_TABLE_POINTER_HIGH_EN = 4;
    localparam logic [7:0] PSS_CTRL_RESET = 8'h00;
    // ---------------------------------------------------------------
    // Vectors and timing
    // ---------------------------------------------------------------
    localparam logic [10:0] PSS_VEC_RESET = 11'h000;
    localparam logic [10:0] PSS_VEC_USB = 11'h004;
    localparam logic [10:0] PSS_VEC_T0 = 11'h008;
    localparam logic [10:0] PSS_VEC_T1 = 11'h00C;
    localparam int PSS_PHASES = 4;
    // ---------------------------------------------------------------
    // Instruction commands from the decoder
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PSS_OP_NEXT = 3'h0,
        PSS_OP_JUMP = 3'h1,
        PSS_OP_CALL = 3'h2,
        PSS_OP_RET = 3'h3,
        PSS_OP_RETURN_FROM_ISR = 3'h4,
        PSS_OP_SKIP = 3'h5,
        PSS_OP_TAB_CUR = 3'h6,
        PSS_OP_TAB_LAST = 3'h7
    } pss_op_type;
    typedef enum logic [3:0] {
        PSS_ST_FETCH = 4'b0001,
        PSS_ST_DUMMY = 4'b0010,
        PSS_ST_TABLE = 4'b0100,
        PSS_ST_IDLE = 4'b1000
    } pss_state_type;
endpackage
`default_nettype wire

// ===== rtl/pss_core.sv
`timescale 1ns/1ps
`default_nettype none
module pss_core
    import pss_pkg::*;
#(
    parameter int PC_W = 11,
    parameter int WORD_W = 15,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Program ROM
    output logic [PC_W-1:0] o_rom_addr,
    input wire logic [WORD_W-1:0] i_rom_data,
    // Decoder command, sampled at last phase of an execute cycle
    input wire logic [2:0] i_op,
    input wire logic [PC_W-1:0] i_op_target,
    input wire logic i_skip_met,
    // Interrupt requests, level
    input wire logic i_irq_usb,
    input wire logic i_irq_t0,
    input wire logic i_irq_t1,
    // Status
    output logic [1:0] o_phase,
    output logic o_cycle_end,
    output logic [PC_W-1:0] o_pc,
    output logic o_exec_valid,
    output logic [WORD_W-1:0] o_instr,
    output logic o_tab_wr,
    output logic [7:0] o_tab_low
);
    initial begin
        if (PC_W != 11 || WORD_W != 15 || DEPTH != 16) begin
            $error("pss_core: unsupported parameters");
        end
    end

    localparam int SW = $clog2(DEPTH);

    // ---------------------------------------------------------------
    // Phase generator
    // ---------------------------------------------------------------
    logic [1:0] phase_reg;
    logic cyc_end;
    assign cyc_end = (phase_reg == 2'(PSS_PHASES - 1));
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [PC_W-1:0] pc_reg;
    logic [7:0] tbl_low_reg;
    logic [7:0] tbl_high_ptr_reg;
    logic [7:0] tbl_latch_reg;
    logic [7:0] ctrl_reg;
    logic [2:0] pend_reg;
    logic [SW-1:0] sp_reg;
    logic [SW:0] depth_reg;
    logic [PC_W-1:0] stack_mem [DEPTH];
    pss_state_type state_reg;
    logic [WORD_W-1:0] instr_reg;
    logic exec_valid_reg;
    logic tab_wr_reg;
    logic [7:0] tab_low_reg;
    logic pc_wr_pend_reg;
    logic [7:0] pc_wr_val_reg;

    logic bus_wr;
    logic full;
    logic [2:0] take;
    logic irq_go;
    logic [PC_W-1:0] vec;
    logic [PC_W-1:0] tab_addr;
    logic [2:0] irq_in;
    logic tab_last_reg;

    assign bus_wr = i_avs_write && i_avs_byteenable[0];
    assign full = (depth_reg == (SW+1)'(DEPTH));
    assign irq_in = {i_irq_t1, i_irq_t0, i_irq_usb};

    // Pending flags: set wins over clear
    assign take = pend_reg & ctrl_reg[3:1];
    assign irq_go = ctrl_reg[PSS_CTRL_GIE] && (take != 3'h0) && !full;
    always_comb begin
        if (take[0]) begin
            vec = PSS_VEC_USB;
        end else if (take[1]) begin
            vec = PSS_VEC_T0;
        end else begin
            vec = PSS_VEC_T1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (irq_in[i]) begin
                    pend_reg[i] <= 1'b1;
                end else if (bus_wr && i_avs_address == PSS_OFS_IRQ &&
                             i_avs_writedata[i]) begin
                    pend_reg[i] <= 1'b0;
                end else if (cyc_end && state_reg == PSS_ST_FETCH && exec_valid_reg && irq_go &&
                             vec == (i == 0 ? PSS_VEC_USB :
                                     i == 1 ? PSS_VEC_T0 : PSS_VEC_T1)) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Table address; top bits from PC, pointer high, or ones
    always_comb begin
        tab_addr[7:0] = tbl_low_reg;
        // Kind is latched: the decoder has moved on by the table cycle
        if (tab_last_reg) begin
            tab_addr[10:8] = 3'h7;
        end else if (ctrl_reg[PSS_CTRL_TABLE_POINTER_HIGH_EN]) begin
            tab_addr[10:8] = tbl_high_ptr_reg[2:0];
        end else begin
            tab_addr[10:8] = pc_reg[10:8];
        end
    end

    // ROM address mux: fetch by PC, table by pointer
    assign o_rom_addr = (state_reg == PSS_ST_TABLE) ? tab_addr : pc_reg;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pc_reg <= PSS_VEC_RESET;
            sp_reg <= '0;
            depth_reg <= '0;
            state_reg <= PSS_ST_IDLE;
            instr_reg <= '0;
            exec_valid_reg <= 1'b0;
            tab_wr_reg <= 1'b0;
            tab_low_reg <= 8'h00;
            tbl_latch_reg <= 8'h00;
            tab_last_reg <= 1'b0;
            ctrl_reg <= PSS_CTRL_RESET;
        end else begin
            tab_wr_reg <= 1'b0;
            if (bus_wr && i_avs_address == PSS_OFS_CTRL) begin
                ctrl_reg <= i_avs_writedata[7:0];
            end
            if (cyc_end) begin
                case (state_reg)
                    PSS_ST_IDLE: begin
                        state_reg <= PSS_ST_FETCH;
                    end
                    PSS_ST_FETCH: begin
                        instr_reg <= i_rom_data;
                        exec_valid_reg <= 1'b1;
                        pc_reg <= pc_reg + 11'h001;
                        if (exec_valid_reg) begin
                            if (irq_go) begin
                                stack_mem[sp_reg] <= pc_reg;
                                sp_reg <= sp_reg + 1'b1;
                                depth_reg <= depth_reg + 1'b1;
                                pc_reg <= vec;
                                ctrl_reg[PSS_CTRL_GIE] <= 1'b0;
                                if (bus_wr && i_avs_address == PSS_OFS_CTRL) begin
                                    ctrl_reg <= i_avs_writedata[7:0] & 8'hFE;
                                end
                                exec_valid_reg <= 1'b0;
                                state_reg <= PSS_ST_DUMMY;
                            end else if (pc_wr_pend_reg) begin
                                pc_reg <= {pc_reg[10:8], pc_wr_val_reg};
                                exec_valid_reg <= 1'b0;
                                state_reg <= PSS_ST_DUMMY;
                            end else begin
                                case (pss_op_type'(i_op))
                                    PSS_OP_JUMP: begin
                                        pc_reg <= i_op_target;
                                        exec_valid_reg <= 1'b0;
                                        state_reg <= PSS_ST_DUMMY;
                                    end
                                    PSS_OP_CALL: begin
                                        stack_mem[sp_reg] <= pc_reg;
                                        sp_reg <= sp_reg + 1'b1;
                                        if (!full) begin
                                            depth_reg <= depth_reg + 1'b1;
                                        end
                                        pc_reg <= i_op_target;
                                        exec_valid_reg <= 1'b0;
                                        state_reg <= PSS_ST_DUMMY;
                                    end
                                    PSS_OP_RET, PSS_OP_RETURN_FROM_ISR: begin
                                        pc_reg <= stack_mem[sp_reg - 1'b1];
                                        sp_reg <= sp_reg - 1'b1;
                                        if (depth_reg != '0) begin
                                            depth_reg <= depth_reg - 1'b1;
                                        end
                                        if (i_op == PSS_OP_RETURN_FROM_ISR) begin
                                            ctrl_reg[PSS_CTRL_GIE] <= 1'b1;
                                        end
                                        exec_valid_reg <= 1'b0;
                                        state_reg <= PSS_ST_DUMMY;
                                    end
                                    PSS_OP_SKIP: begin
                                        if (i_skip_met) begin
                                            pc_reg <= pc_reg + 11'h001;
                                            exec_valid_reg <= 1'b0;
                                            state_reg <= PSS_ST_DUMMY;
                                        end
                                    end
                                    PSS_OP_TAB_CUR, PSS_OP_TAB_LAST: begin
                                        // Fetched word is held and runs after the table cycle
                                        pc_reg <= pc_reg;
                                        tab_last_reg <= (i_op == PSS_OP_TAB_LAST);
                                        exec_valid_reg <= 1'b0;
                                        state_reg <= PSS_ST_TABLE;
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                        end
                    end
                    PSS_ST_TABLE: begin
                        tab_low_reg <= i_rom_data[7:0];
                        tbl_latch_reg <= {1'b0, i_rom_data[14:8]};
                        tab_wr_reg <= 1'b1;
                        exec_valid_reg <= 1'b1;
                        pc_reg <= pc_reg + 11'h001;
                        state_reg <= PSS_ST_FETCH;
                    end
                    PSS_ST_DUMMY: begin
                        // Dummy slot fetches at the new PC, so only one cycle is lost
                        instr_reg <= i_rom_data;
                        exec_valid_reg <= 1'b1;
                        pc_reg <= pc_reg + 11'h001;
                        state_reg <= PSS_ST_FETCH;
                    end
                    default: begin
                        state_reg <= PSS_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    // PC low writes are held until the next fetch boundary
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pc_wr_pend_reg <= 1'b0;
            pc_wr_val_reg <= 8'h00;
        end else if (bus_wr && i_avs_address == PSS_OFS_PC_LOW) begin
            pc_wr_pend_reg <= 1'b1;
            pc_wr_val_reg <= i_avs_writedata[7:0];
        end else if (cyc_end && state_reg == PSS_ST_FETCH && exec_valid_reg && !irq_go) begin
            pc_wr_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tbl_low_reg <= 8'h00;
            tbl_high_ptr_reg <= 8'h00;
        end else if (bus_wr) begin
            if (i_avs_address == PSS_OFS_TBL_LOW) begin
                tbl_low_reg <= i_avs_writedata[7:0];
            end
            if (i_avs_address == PSS_OFS_TBL_HIGH_PTR) begin
                tbl_high_ptr_reg <= i_avs_writedata[7:0];
            end
        end
    end

    // Zero-wait slave; read data registered one cycle later would break timing
    assign o_avs_waitrequest = 1'b0;
    always_comb begin
        case (i_avs_address)
            PSS_OFS_PC_LOW: o_avs_readdata = {24'h0, pc_reg[7:0]};
            PSS_OFS_TBL_LOW: o_avs_readdata = {24'h0, tbl_low_reg};
            PSS_OFS_TBL_HIGH_LATCH: o_avs_readdata = {24'h0, tbl_latch_reg};
            PSS_OFS_TBL_HIGH_PTR: o_avs_readdata = {24'h0, tbl_high_ptr_reg};
            PSS_OFS_CTRL: o_avs_readdata = {24'h0, ctrl_reg};
            PSS_OFS_STATUS: o_avs_readdata = {27'h0, depth_reg};
            PSS_OFS_IRQ: o_avs_readdata = {29'h0, pend_reg};
            default: o_avs_readdata = 32'h0;
        endcase
    end

    assign o_phase = phase_reg;
    assign o_cycle_end = cyc_end;
    assign o_pc = pc_reg;
    assign o_exec_valid = exec_valid_reg;
    assign o_instr = instr_reg;
    assign o_tab_wr = tab_wr_reg;
    assign o_tab_low = tab_low_reg;
endmodule
`default_nettype wire

// ===== bench/pss_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module pss_core_props
    import pss_pkg::*;
#(
    parameter int PC_W = 11
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Decoder
    input wire logic [2:0] i_op,
    input wire logic [PC_W-1:0] i_op_target,
    input wire logic i_skip_met,
    // Status
    input wire logic [1:0] o_phase,
    input wire logic o_cycle_end,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic o_exec_valid,
    input wire logic o_tab_wr
);
    // ---------------------------------------------------------------
    // Sequencer properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic slot;
    // Decoder commands only count at an executing cycle end
    assign slot = o_cycle_end && o_exec_valid;
    property p_phase_step; !o_cycle_end |=> o_phase == $past(o_phase) + 2'h1; endproperty
    property p_cycle_len; o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end; endproperty
    property p_pc_hold; !o_cycle_end |=> $stable(o_pc); endproperty
    property p_reset_pc; $past(i_rst) |-> o_pc == '0 && !o_exec_valid; endproperty
    property p_jump_pc; slot && i_op == PSS_OP_JUMP |=> o_pc == $past(i_op_target); endproperty
    property p_xfer_dummy;
        slot && i_op inside {PSS_OP_JUMP, PSS_OP_CALL, PSS_OP_RET, PSS_OP_RETURN_FROM_ISR}
        |=> !o_exec_valid [*4] ##1 o_exec_valid;
    endproperty
    property p_skip_dummy;
        slot && i_op == PSS_OP_SKIP && i_skip_met |=> !o_exec_valid [*4] ##1 o_exec_valid;
    endproperty
    property p_skip_none;
        slot && i_op == PSS_OP_SKIP && !i_skip_met |=> o_exec_valid;
    endproperty
    property p_table_wr;
        slot && i_op inside {PSS_OP_TAB_CUR, PSS_OP_TAB_LAST}
        |=> !o_tab_wr [*4] ##1 o_tab_wr ##1 !o_tab_wr;
    endproperty
    a_phase_step: assert property (p_phase_step)
        else $error("phase counter did not advance");
    a_cycle_len: assert property (p_cycle_len)
        else $error("instruction cycle not four clocks");
    a_pc_hold: assert property (p_pc_hold)
        else $error("pc moved inside a cycle");
    a_reset_pc: assert property (p_reset_pc)
        else $error("pc not zero after reset");
    a_jump_pc: assert property (p_jump_pc)
        else $error("jump target not loaded");
    a_xfer_dummy: assert property (p_xfer_dummy)
        else $error("no dummy cycle after transfer");
    a_skip_dummy: assert property (p_skip_dummy)
        else $error("no dummy cycle after skip");
    a_skip_none: assert property (p_skip_none)
        else $error("unmet skip dropped an instruction");
    a_table_wr: assert property (p_table_wr)
        else $error("table write not at end of second cycle");
    c_table: cover property (slot && i_op == PSS_OP_TAB_LAST);
    c_call: cover property (slot && i_op == PSS_OP_CALL);
    c_skip: cover property (slot && i_op == PSS_OP_SKIP && i_skip_met);
endmodule
bind pss_core pss_core_props #(.PC_W(PC_W)) u_props (
    .i_clk, .i_rst, .i_op, .i_op_target, .i_skip_met, .o_phase,
    .o_cycle_end, .o_pc, .o_exec_valid, .o_tab_wr
);
`default_nettype wire

// ===== bench/pss_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module pss_rom_model (
    // Clock
    input wire logic i_clk,
    // Program ROM
    input wire logic [10:0] i_addr,
    output logic [14:0] o_data,
    // Interrupt sources
    input wire logic [2:0] i_fire,
    output logic [2:0] o_irq
);
    // Address-derived words, so a wrong fetch address always shows
    assign o_data = {4'hA, i_addr};
    initial o_irq = 3'h0;
    always @(posedge i_clk) begin
        o_irq <= i_fire;
    end
endmodule
`default_nettype wire

// ===== bench/program_sequencer_stack_tb.sv
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_stack_tb;
    import pss_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [10:0] o_rom_addr;
    logic [14:0] i_rom_data;
    logic [2:0] i_op = 3'h0;
    logic [10:0] i_op_target = 11'h000;
    logic i_skip_met = 1'b0;
    logic [2:0] fire = 3'h0;
    logic [2:0] irq;
    logic [1:0] o_phase;
    logic o_cycle_end;
    logic o_exec_valid;
    logic [14:0] o_instr;
    logic o_tab_wr;
    logic [7:0] o_tab_low;
    int n_fail = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'hBF8F;
    logic [31:0] q_rd[$];
    logic [7:0] q_tab[$];
    pss_core dut (
        .i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_rom_addr, .i_rom_data,
        .i_op, .i_op_target, .i_skip_met, .i_irq_usb(irq[0]), .i_irq_t0(irq[1]),
        .i_irq_t1(irq[2]), .o_phase, .o_cycle_end, .o_pc(), .o_exec_valid, .o_instr,
        .o_tab_wr, .o_tab_low
    );
    pss_rom_model u_rom (.i_clk, .i_addr(o_rom_addr), .o_data(i_rom_data), .i_fire(fire),
        .o_irq(irq));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [10:0] site(input int i);
        return 11'h200 + 11'(16 * i);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_avs_waitrequest !== 1'b0 && k < 50);
        guard(k, 50);
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic wrq(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdq(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Command lands on the phase 3 edge of an executing cycle
    task automatic issue(input logic [2:0] o, input logic [10:0] t, input logic s);
        int k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (!(o_phase === 2'h2 && o_exec_valid === 1'b1) && k < 200);
        guard(k, 200);
        @(posedge i_clk);
        i_op <= o;
        i_op_target <= t;
        i_skip_met <= s;
        @(posedge i_clk);
        i_op <= PSS_OP_NEXT;
        i_skip_met <= 1'b0;
    endtask
    // First instruction executed after the next dummy cycle
    task automatic land(input logic [10:0] a);
        int k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (o_exec_valid !== 1'b0 && k < 200);
        do begin
            @(negedge i_clk);
            k++;
        end while (o_exec_valid !== 1'b1 && k < 400);
        guard(k, 400);
        chk("instr", {17'h0, 4'hA, a}, {17'h0, o_instr});
    endtask
    always @(posedge i_clk) begin
        if (i_avs_read && o_avs_waitrequest === 1'b0) begin
            if (q_rd.size() == 0) chk("readq", 32'h1, 32'h0);
            else chk("readdata", q_rd.pop_front(), o_avs_readdata);
        end
        if (o_tab_wr === 1'b1) begin
            if (q_tab.size() == 0) chk("tabq", 32'h1, 32'h0);
            else chk("tab_low", {24'h0, q_tab.pop_front()}, {24'h0, o_tab_low});
        end
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        n_fail++;
        tally_and_finish();
    end
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        logic [10:0] tg;
        logic [7:0] lo;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        land(PSS_VEC_RESET);
        rdq(PSS_OFS_TBL_LOW, 32'h0);
        rdq(PSS_OFS_STATUS, 32'h0);
        rdq(8'h40, 32'h0);
        $display("test reset done");
        for (int j = 0; j < 4; j++) begin
            tg = 11'(rnd());
            issue(PSS_OP_JUMP, tg, 1'b0);
            land(tg);
        end
        issue(PSS_OP_JUMP, 11'h5A0, 1'b0);
        land(11'h5A0);
        issue(PSS_OP_SKIP, 11'h000, 1'b0);
        issue(PSS_OP_SKIP, 11'h000, 1'b1);
        land(11'h5A3);
        issue(PSS_OP_CALL, 11'h2A0, 1'b0);
        land(11'h2A0);
        rdq(PSS_OFS_STATUS, 32'h1);
        issue(PSS_OP_RET, 11'h000, 1'b0);
        land(11'h5A4);
        wrq(PSS_OFS_PC_LOW, 32'h34);
        land(11'h534);
        $display("test flow done");
        lo = 8'(rnd());
        wrq(PSS_OFS_TBL_LOW, {24'h0, lo});
        wrq(PSS_OFS_TBL_HIGH_PTR, 32'h3);
        rdq(PSS_OFS_TBL_HIGH_PTR, 32'h3);
        for (int j = 0; j < 3; j++) begin
            wrq(PSS_OFS_CTRL, (j == 1) ? 32'h10 : 32'h0);
            q_tab.push_back(lo);
            issue((j == 2) ? PSS_OP_TAB_LAST : PSS_OP_TAB_CUR, 11'h000, 1'b0);
            repeat (8) @(posedge i_clk);
            wrq(PSS_OFS_TBL_HIGH_LATCH, 32'hFF);
            rdq(PSS_OFS_TBL_HIGH_LATCH, (j == 0) ? 32'h55 : (j == 1) ? 32'h53 : 32'h57);
        end
        $display("test table done");
        for (int j = 0; j < 3; j++) begin
            issue(PSS_OP_NEXT, 11'h000, 1'b0);
            wrq(PSS_OFS_CTRL, 32'h1 | (32'h2 << j));
            fire <= 3'h1 << j;
            @(posedge i_clk);
            fire <= 3'h0;
            land((j == 0) ? PSS_VEC_USB : (j == 1) ? PSS_VEC_T0 : PSS_VEC_T1);
            rdq(PSS_OFS_CTRL, 32'h2 << j);
            wrq(PSS_OFS_IRQ, 32'h7);
            issue(PSS_OP_RETURN_FROM_ISR, 11'h000, 1'b0);
        end
        $display("test irq done");
        issue(PSS_OP_JUMP, 11'h100, 1'b0);
        land(11'h100);
        for (int j = 1; j < 18; j++) begin
            issue(PSS_OP_CALL, site(j), 1'b0);
            land(site(j));
        end
        rdq(PSS_OFS_STATUS, 32'h10);
        wrq(PSS_OFS_CTRL, 32'h3);
        fire <= 3'h1;
        @(posedge i_clk);
        fire <= 3'h0;
        issue(PSS_OP_JUMP, 11'h700, 1'b0);
        land(11'h700);
        issue(PSS_OP_RET, 11'h000, 1'b0);
        land(site(16) + 11'h1);
        land(PSS_VEC_USB);
        wrq(PSS_OFS_IRQ, 32'h7);
        issue(PSS_OP_RETURN_FROM_ISR, 11'h000, 1'b0);
        land(site(16) + 11'h2);
        for (int j = 15; j > 0; j--) begin
            issue(PSS_OP_RET, 11'h000, 1'b0);
            land(site(j) + 11'h1);
        end
        rdq(PSS_OFS_STATUS, 32'h0);
        $display("test stack done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
